// ==== hw/crcu_pkg.sv ====
// Constants, register map and types of the checksum_unit.
// Assumes an 8-bit special-function-register bus on the system clock.
package crcu_pkg;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   // Register byte addresses
   localparam logic [7:0] ADDR_RESULT = 8'h91;
   localparam logic [7:0] ADDR_CTRL = 8'h92;
   localparam logic [7:0] ADDR_INPUT = 8'h93;
   localparam logic [7:0] ADDR_AUTO = 8'h96;
   localparam logic [7:0] ADDR_COUNT = 8'h97;
   // crc_control fields
   localparam int CTRL_SEL_BIT = 4;
   localparam int CTRL_INIT_BIT = 3;
   localparam int CTRL_VAL_BIT = 2;
   localparam int CTRL_PTR_LSB = 0;
   localparam logic [2:0] CTRL_UNUSED_READ = 3'h0;
   // auto_mode_control fields
   localparam int AUTO_EN_BIT = 7;
   localparam int START_W = 6;
   localparam int COUNT_W = 8;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] INPUT_RESET = 8'h00;
   localparam logic [7:0] AUTO_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [31:0] RESULT_RESET = 32'h00000000;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // Polynomials and seeds
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] POLY32 = 32'h04C11DB7;
   localparam logic [31:0] POLY32_REFL = 32'hEDB88320;
   localparam logic [31:0] SEED_ZERO = 32'h00000000;
   localparam logic [31:0] SEED_ONES = 32'hFFFFFFFF;
   localparam int BITS_PER_BYTE = 8;
   // Flash sectors
   localparam int SECTOR_BYTES = 1024;
   localparam int SECTOR_SHIFT = 10;
   localparam int FADDR_W = 16;
   localparam int BCNT_W = COUNT_W + SECTOR_SHIFT;
   localparam logic [1:0] PTR_STEP = 2'h1;
   // Auto-mode sequencer
   typedef enum logic [3:0] {
      CRCU_IDLE = 4'h1,
      CRCU_FETCH = 4'h2,
      CRCU_WAIT = 4'h4,
      CRCU_DRAIN = 4'h8
   } crcu_state_t;
endpackage

// ==== hw/crcu_stream_if.sv ====
// Byte stream carrier between the engine and its FIFO.
// Assumes valid/ready transfer on every clock edge where both are high.
`timescale 1ns/1ns
`default_nettype none
interface crcu_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hw/crcu_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the head word is shown while valid is high.
`timescale 1ns/1ns
`default_nettype none
module crcu_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   crcu_stream_if.snk push,
   crcu_stream_if.src pop
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic do_push;
   logic do_pop;
   assign push.ready = (count != CNT_FULL);
   assign pop.valid = (count != '0);
   assign pop.data = mem[rd_ptr];
   always_comb begin
      do_push = push.valid && push.ready;
      do_pop = pop.valid && pop.ready;
      next_wr_ptr = do_push ? wr_ptr + PTR_ONE : wr_ptr;
      next_rd_ptr = do_pop ? rd_ptr + PTR_ONE : rd_ptr;
      next_count = count;
      if (do_push && !do_pop) begin
         next_count = count + CNT_ONE;
      end else if (do_pop && !do_push) begin
         next_count = count - CNT_ONE;
      end
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
   // Storage carries no reset; it is never read while empty
   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem[wr_ptr] <= push.data;
      end
   end
endmodule // crcu_fifo
`default_nettype wire

// ==== hw/crcu_engine.sv ====
// Top of the checksum_unit: register slave, CRC datapath, flash sequencer.
// Assumes a CPU bus on clk_i and a flash port answering on the same clock.
// Operation
// RL1: Select bit 1 gives CRC-16 poly 0x1021
// RL2: CRC-16 runs most significant bit first
// RL3: CRC-16 XORs byte into upper eight bits
// RL4: Eight shifts left, XOR poly on bit 15
// RL5: Select bit 0 gives CRC-32 poly 0x04C11DB7
// RL6: CRC-32 is bit-reflected throughout
// RL7: CRC-32 XORs low byte, shifts right eight times
// RL8: Control bit 4 picks polynomial and length
// RL9: Seed bit picks all zeros or ones
// RL10: Writing init bit loads seed into result
// RL11: Software picks poly, seed, then initializes
// RL12: Each input byte write folds into result
// RL13: Auto mode walks whole 1024-byte flash sectors
// RL14: Control write with auto enable launches run
// RL15: CPU stalls until sector run completes
// RL16: Benign three-byte instruction follows launch write
// RL17: Software clears auto enable before readout
// RL18: Byte pointer selects and auto-increments on access
// RL19: Data port accesses byte under pointer
// RL20: 32-bit pointer maps four result bytes
// RL21: 16-bit pointer aliases two result bytes
// RL22: Result held until init, write, or input
// RL23: Control bits 7..5 read zero, ignore writes
// RL24: 16-bit mode ignores upper sixteen result bits
`timescale 1ns/1ns
`default_nettype none
module crcu_engine
   import crcu_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   output logic [7:0] sfr_rdata_o,
   output logic cpu_stall_o,
   output logic flash_rd_o,
   output logic [FADDR_W-1:0] flash_addr_o,
   input wire logic [7:0] flash_data_i,
   input wire logic flash_valid_i
);

   function automatic logic [15:0] crc16_byte(input logic [15:0] acc, input logic [7:0] din);
      logic [15:0] a;
      a = acc ^ {din, 8'h00}; // RL3
      for (int i = 0; i < BITS_PER_BYTE; i++) begin
         if (a[15]) begin
            a = {a[14:0], 1'b0} ^ POLY16; // RL1 RL2 RL4
         end else begin
            a = {a[14:0], 1'b0}; // RL4
         end
      end
      return a;
   endfunction

   function automatic logic [31:0] crc32_byte(input logic [31:0] acc, input logic [7:0] din);
      logic [31:0] a;
      a = acc ^ {24'h000000, din}; // RL7
      for (int i = 0; i < BITS_PER_BYTE; i++) begin
         if (a[0]) begin
            a = {1'b0, a[31:1]} ^ POLY32_REFL; // RL5 RL6 RL7
         end else begin
            a = {1'b0, a[31:1]}; // RL6 RL7
         end
      end
      return a;
   endfunction

   // Byte lane under the pointer; 16-bit mode aliases the upper pointer values
   function automatic logic [1:0] lane_of(input logic [1:0] ptr, input logic sel16);
      return sel16 ? {1'b0, ptr[0]} : ptr; // RL20 RL21
   endfunction

   crcu_stream_if #(.WIDTH(BYTE_W)) push_bus();
   crcu_stream_if #(.WIDTH(BYTE_W)) pop_bus();

   crcu_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .push(push_bus),
      .pop(pop_bus)
   );

   // Register state
   logic poly_sel;
   logic seed_sel;
   logic [1:0] result_ptr;
   logic [31:0] result;
   logic [7:0] byte_input;
   logic auto_en;
   logic [START_W-1:0] start_sector;
   logic [COUNT_W-1:0] sector_count;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic next_poly_sel;
   logic next_seed_sel;
   logic [1:0] next_result_ptr;
   logic [31:0] next_result;
   logic [7:0] next_byte_input;
   logic next_auto_en;
   logic [START_W-1:0] next_start_sector;
   logic [COUNT_W-1:0] next_sector_count;

   // Sequencer state
   crcu_state_t state;
   crcu_state_t next_state;
   logic [FADDR_W-1:0] fetch_addr;
   logic [FADDR_W-1:0] next_fetch_addr;
   logic [BCNT_W-1:0] bytes_left;
   logic [BCNT_W-1:0] next_bytes_left;

   logic wr_ctrl;
   logic wr_result;
   logic rd_result;
   logic wr_input;
   logic [1:0] lane;
   logic [31:0] seed;
   logic [31:0] folded;
   logic fold_now;
   logic launch;

   always_comb begin
      wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_CTRL);
      wr_result = sfr_wr_i && (sfr_addr_i == ADDR_RESULT);
      rd_result = sfr_rd_i && (sfr_addr_i == ADDR_RESULT);
      wr_input = sfr_wr_i && (sfr_addr_i == ADDR_INPUT);
      lane = lane_of(result_ptr, poly_sel);
      seed = seed_sel ? SEED_ONES : SEED_ZERO; // RL9
      launch = wr_ctrl && auto_en; // RL14
   end

   // Bytes from software and from flash share one path into the FIFO
   always_comb begin
      if (state == CRCU_WAIT) begin
         push_bus.valid = flash_valid_i; // RL13
         push_bus.data = flash_data_i;
      end else begin
         push_bus.valid = wr_input; // RL12
         push_bus.data = sfr_wdata_i;
      end
   end

   // Control and result writes take the cycle; the fold waits one
   always_comb begin
      pop_bus.ready = !(wr_ctrl || wr_result);
      fold_now = pop_bus.valid && pop_bus.ready;
      if (poly_sel) begin
         folded = {16'h0000, crc16_byte(result[15:0], pop_bus.data)}; // RL24 RL8
      end else begin
         folded = crc32_byte(result, pop_bus.data); // RL8
      end
   end

   // Register file next values
   always_comb begin
      next_poly_sel = poly_sel;
      next_seed_sel = seed_sel;
      next_result_ptr = result_ptr;
      next_result = result; // RL22
      next_byte_input = byte_input;
      next_auto_en = auto_en;
      next_start_sector = start_sector;
      next_sector_count = sector_count;
      next_rdata = rdata;
      if (wr_ctrl) begin
         // Bits 7..5 are simply not stored
         next_poly_sel = sfr_wdata_i[CTRL_SEL_BIT]; // RL23 RL8
         next_seed_sel = sfr_wdata_i[CTRL_VAL_BIT];
         next_result_ptr = sfr_wdata_i[CTRL_PTR_LSB +: 2];
         if (sfr_wdata_i[CTRL_INIT_BIT]) begin
            // Seed taken from the value written in the same access
            next_result = sfr_wdata_i[CTRL_VAL_BIT] ? SEED_ONES : SEED_ZERO; // RL10 RL9
         end
      end else if (wr_result) begin
         next_result[lane*8 +: 8] = sfr_wdata_i; // RL19
         next_result_ptr = result_ptr + PTR_STEP; // RL18
      end else if (fold_now) begin
         next_result = folded; // RL12
      end
      if (rd_result) begin
         next_result_ptr = result_ptr + PTR_STEP; // RL18
      end
      if (wr_input) begin
         next_byte_input = sfr_wdata_i;
      end
      if (sfr_wr_i && (sfr_addr_i == ADDR_AUTO)) begin
         next_auto_en = sfr_wdata_i[AUTO_EN_BIT];
         next_start_sector = sfr_wdata_i[START_W-1:0];
      end
      if (sfr_wr_i && (sfr_addr_i == ADDR_COUNT)) begin
         next_sector_count = sfr_wdata_i;
      end
      if (sfr_rd_i) begin
         case (sfr_addr_i)
            ADDR_RESULT: next_rdata = result[lane*8 +: 8]; // RL19 RL20 RL21
            ADDR_CTRL: next_rdata = {CTRL_UNUSED_READ, poly_sel, 1'b0, seed_sel,
                                     result_ptr}; // RL23
            ADDR_INPUT: next_rdata = byte_input;
            ADDR_AUTO: next_rdata = {auto_en, 1'b0, start_sector};
            ADDR_COUNT: next_rdata = sector_count;
            default: next_rdata = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         poly_sel <= CTRL_RESET[CTRL_SEL_BIT];
         seed_sel <= CTRL_RESET[CTRL_VAL_BIT];
         result_ptr <= CTRL_RESET[CTRL_PTR_LSB +: 2];
         result <= RESULT_RESET;
         byte_input <= INPUT_RESET;
         auto_en <= AUTO_RESET[AUTO_EN_BIT];
         start_sector <= AUTO_RESET[START_W-1:0];
         sector_count <= COUNT_RESET;
         rdata <= READ_ZERO;
      end else begin
         poly_sel <= next_poly_sel;
         seed_sel <= next_seed_sel;
         result_ptr <= next_result_ptr;
         result <= next_result;
         byte_input <= next_byte_input;
         auto_en <= next_auto_en;
         start_sector <= next_start_sector;
         sector_count <= next_sector_count;
         rdata <= next_rdata;
      end
   end

   // Flash sequencer: one read outstanding, issued only when the FIFO has room,
   // so a returning byte can never meet a full FIFO.
   always_comb begin
      next_state = state;
      next_fetch_addr = fetch_addr;
      next_bytes_left = bytes_left;
      flash_rd_o = 1'b0;
      case (state)
         CRCU_IDLE: begin
            if (launch) begin
               next_fetch_addr = {start_sector, {SECTOR_SHIFT{1'b0}}}; // RL13
               next_bytes_left = {sector_count, {SECTOR_SHIFT{1'b0}}}; // RL13
               if (sector_count == '0) begin
                  next_state = CRCU_DRAIN;
               end else begin
                  next_state = CRCU_FETCH; // RL14
               end
            end
         end
         CRCU_FETCH: begin
            if (push_bus.ready) begin
               flash_rd_o = 1'b1;
               next_state = CRCU_WAIT;
            end
         end
         CRCU_WAIT: begin
            if (flash_valid_i) begin
               next_fetch_addr = fetch_addr + 16'h0001;
               next_bytes_left = bytes_left - 18'h00001;
               if (bytes_left == 18'h00001) begin
                  next_state = CRCU_DRAIN;
               end else begin
                  next_state = CRCU_FETCH;
               end
            end
         end
         CRCU_DRAIN: begin
            if (!pop_bus.valid) begin
               next_state = CRCU_IDLE;
            end
         end
         default: begin
            next_state = CRCU_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= CRCU_IDLE;
         fetch_addr <= '0;
         bytes_left <= '0;
      end else begin
         state <= next_state;
         fetch_addr <= next_fetch_addr;
         bytes_left <= next_bytes_left;
      end
   end

   // Stall rises the cycle after a launch, so the launching write is a plain access;
   // queued input bytes stall too, so a result read never sees a stale value.
   assign cpu_stall_o = (state != CRCU_IDLE) || pop_bus.valid
                        || !push_bus.ready; // RL15 RL16
   assign flash_addr_o = fetch_addr;
   assign sfr_rdata_o = rdata;

endmodule // crcu_engine
`default_nettype wire

// ==== dv/crcu_engine_sva.sv ====
// Checker for the checksum_unit top: bus answers, fold stall, flash fetch order.
// Assumes it is bound to crcu_engine and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module crcu_engine_sva
   import crcu_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic cpu_stall_o,
   input wire logic flash_rd_o,
   input wire logic [FADDR_W-1:0] flash_addr_o,
   input wire logic [7:0] flash_data_i,
   input wire logic flash_valid_i
);
   logic take;
   logic launch;
   logic auto_en;
   logic run;
   logic seen;
   logic pend;
   logic [START_W-1:0] start_q;
   logic [COUNT_W-1:0] count_q;
   logic [FADDR_W-1:0] last_q;
   logic [BCNT_W-1:0] nreq;
   assign take = sfr_wr_i && !cpu_stall_o;
   assign launch = take && sfr_addr_i == ADDR_CTRL && auto_en;
   // Shadow of the auto setup, so fetch order can be judged from ports alone
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         auto_en <= 1'b0;
         start_q <= '0;
         count_q <= '0;
         run <= 1'b0;
         seen <= 1'b0;
         pend <= 1'b0;
         last_q <= '0;
         nreq <= '0;
      end else begin
         if (take && sfr_addr_i == ADDR_AUTO) begin
            auto_en <= sfr_wdata_i[AUTO_EN_BIT];
            start_q <= sfr_wdata_i[START_W-1:0];
         end
         if (take && sfr_addr_i == ADDR_COUNT) count_q <= sfr_wdata_i;
         if (launch) begin
            run <= 1'b1;
            seen <= 1'b0;
            nreq <= '0;
         end else if (run && !cpu_stall_o) begin
            run <= 1'b0;
         end
         if (flash_rd_o) begin
            seen <= 1'b1;
            last_q <= flash_addr_o;
            nreq <= nreq + 1'b1;
         end
         pend <= flash_rd_o | (pend & ~flash_valid_i);
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence fold_done;
      cpu_stall_o ##[1:3] !cpu_stall_o;
   endsequence
   reset_quiet_a: assert property ($rose(nrst_i) |-> sfr_rdata_o == 8'h00 && !cpu_stall_o
      && !flash_rd_o) else $error("outputs not idle after reset");
   ctrl_read_a: assert property (sfr_rd_i && !cpu_stall_o && sfr_addr_i == ADDR_CTRL
      |=> sfr_rdata_o[7:5] == 3'h0 && !sfr_rdata_o[CTRL_INIT_BIT])
      else $error("control unused bits not zero");
   fold_stall_a: assert property (take && sfr_addr_i == ADDR_INPUT |=> fold_done)
      else $error("byte fold stall wrong");
   launch_stall_a: assert property (launch |=> cpu_stall_o)
      else $error("launch did not stall");
   fetch_stall_a: assert property (flash_rd_o |-> cpu_stall_o)
      else $error("fetch while cpu runs");
   addr_hold_a: assert property (pend && !flash_valid_i
      |-> !flash_rd_o && $stable(flash_addr_o))
      else $error("fetch address moved while outstanding");
   addr_step_a: assert property (flash_rd_o |-> flash_addr_o ==
      (seen ? last_q + 16'h0001 : {start_q, 10'h000})) else $error("fetch address out of order");
   run_length_a: assert property (run && $fell(cpu_stall_o) |-> nreq == {count_q, 10'h000})
      else $error("auto run fetched wrong byte count");
endmodule // crcu_engine_sva
`default_nettype wire

// ==== dv/crcu_flash_model.sv ====
// Flash side model: one byte per fetch, answers fast and slow in turn.
// Assumes one outstanding fetch, as the engine promises.
`timescale 1ns/1ns
`default_nettype none
module crcu_flash_model (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic rd_i,
   input wire logic [15:0] addr_i,
   output logic [7:0] data_o,
   output logic valid_o
);
   logic pend;
   logic slow;
   logic [1:0] wait_q;
   logic [15:0] addr_q;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pend <= 1'b0;
         slow <= 1'b0;
         wait_q <= 2'h0;
         addr_q <= 16'h0000;
         data_o <= 8'h00;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         // Undriven data toggles, so a stale byte is never taken for good
         data_o <= ~data_o;
         if (rd_i) begin
            pend <= 1'b1;
            addr_q <= addr_i;
            wait_q <= slow ? 2'h2 : 2'h0;
            slow <= ~slow;
         end else if (pend && wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else if (pend) begin
            pend <= 1'b0;
            valid_o <= 1'b1;
            data_o <= addr_q[7:0] ^ addr_q[15:8] ^ 8'h5A;
         end
      end
   end
endmodule // crcu_flash_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Testbench: register scenarios, CRC folds in both modes, an automatic flash run.
// Assumes crcu_engine, its checker and the flash model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import crcu_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic stall;
   logic frd;
   logic fvalid;
   logic [15:0] faddr;
   logic [7:0] fdata;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   always #20 clk_i = ~clk_i;
   crcu_engine uut (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
      .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .cpu_stall_o(stall), .flash_rd_o(frd),
      .flash_addr_o(faddr), .flash_data_i(fdata), .flash_valid_i(fvalid));
   crcu_flash_model flash (.clk_i(clk_i), .nrst_i(nrst_i), .rd_i(frd), .addr_i(faddr),
      .data_o(fdata), .valid_o(fvalid));
   function automatic logic [31:0] fold(logic [31:0] acc, logic [7:0] b, logic m16);
      if (m16) begin
         acc = {16'h0000, acc[15:0] ^ {b, 8'h00}};
         for (int i = 0; i < 8; i++) acc[15:0] = {acc[14:0], 1'b0} ^ (acc[15] ? 16'h1021 : 16'h0);
      end else begin
         acc = acc ^ {24'h0, b};
         for (int i = 0; i < 8; i++) acc = (acc >> 1) ^ (acc[0] ? 32'hEDB88320 : 32'h0);
      end
      return acc;
   endfunction
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // No access is started while the engine stalls the cpu
   task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      while (stall !== 1'b0) @(negedge clk_i);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      wr <= is_wr;
      rd <= !is_wr;
      @(posedge clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(what, {24'h0, rdata}, {24'h0, exp});
   endtask
   task automatic t_reset;
      rd_chk("control", ADDR_CTRL, 8'h00);
      rd_chk("byte_input", ADDR_INPUT, 8'h00);
      rd_chk("auto", ADDR_AUTO, 8'h00);
      rd_chk("count", ADDR_COUNT, 8'h00);
      rd_chk("unmapped", 8'h90, 8'h00);
   endtask
   task automatic t_ctrl;
      bus(1'b1, ADDR_CTRL, 8'hFF);
      rd_chk("ctrl_bits", ADDR_CTRL, 8'h17);
      bus(1'b1, ADDR_INPUT, 8'h3C);
      rd_chk("input_back", ADDR_INPUT, 8'h3C);
   endtask
   task automatic t_crc(input logic m16, input logic seed, input logic [39:0] bytes,
      input int n, input logic [31:0] tbl);
      logic [31:0] acc;
      logic [7:0] b;
      acc = seed ? (m16 ? 32'h0000FFFF : 32'hFFFFFFFF) : 32'h0;
      bus(1'b1, ADDR_CTRL, {3'h0, m16, 1'b1, seed, 2'h0});
      for (int i = n - 1; i >= 0; i--) begin
         b = bytes[8*i +: 8];
         bus(1'b1, ADDR_INPUT, b);
         acc = fold(acc, b, m16);
      end
      if (tbl !== 32'h0) chk("table", acc, tbl);
      // Six reads walk past the wrap of the pointer
      for (int k = 0; k < 6; k++) begin
         bus(1'b0, ADDR_RESULT, 8'h00);
         b = m16 ? acc[8*(k%2) +: 8] : acc[8*(k%4) +: 8];
         chk("result_byte", {24'h0, rdata}, {24'h0, b});
      end
   endtask
   task automatic t_wrdata;
      bus(1'b1, ADDR_CTRL, 8'h00);
      for (int k = 0; k < 4; k++) bus(1'b1, ADDR_RESULT, 8'(17 * (k + 1)));
      bus(1'b1, ADDR_CTRL, 8'h02);
      rd_chk("ptr_lane", ADDR_RESULT, 8'h33);
      rd_chk("ptr_next", ADDR_RESULT, 8'h44);
      rd_chk("ptr_wrap", ADDR_RESULT, 8'h11);
   endtask
   task automatic t_auto;
      logic [31:0] acc;
      logic [15:0] a;
      acc = 32'hFFFFFFFF;
      bus(1'b1, ADDR_CTRL, 8'h0C);
      bus(1'b1, ADDR_COUNT, 8'h01);
      bus(1'b1, ADDR_AUTO, 8'h81);
      bus(1'b1, ADDR_CTRL, 8'h00);
      bus(1'b1, ADDR_AUTO, 8'h01);
      for (int i = 0; i < 1024; i++) begin
         a = 16'(1024 + i);
         acc = fold(acc, a[7:0] ^ a[15:8] ^ 8'h5A, 1'b0);
      end
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, ADDR_RESULT, 8'h00);
         chk("auto_result", {24'h0, rdata}, {24'h0, acc[8*k +: 8]});
      end
      // Zero sectors: launch drains at once and leaves the result alone
      bus(1'b1, ADDR_COUNT, 8'h00);
      bus(1'b1, ADDR_AUTO, 8'h81);
      bus(1'b1, ADDR_CTRL, 8'h00);
      bus(1'b1, ADDR_AUTO, 8'h01);
      rd_chk("empty_run", ADDR_RESULT, acc[7:0]);
   endtask
   task close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      t_reset;
      t_ctrl;
      t_crc(1'b1, 1'b0, 40'h63, 1, 32'h0);
      t_crc(1'b1, 1'b1, 40'h0000AABBCC, 5, 32'h0000B166);
      t_crc(1'b0, 1'b1, 40'h63, 1, 32'hF9462090);
      t_crc(1'b0, 1'b1, 40'hAABBCC, 3, 32'h41B207B3);
      t_crc(1'b0, 1'b1, 40'h0000AABBCC, 5, 32'h78D129BC);
      t_wrdata;
      t_auto;
      close_out;
   end
   // One sector run needs about 4100 cycles; the ceiling leaves wide margin
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         close_out;
      end
   end
endmodule // tb_top
bind crcu_engine crcu_engine_sva chk_u (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
   .cpu_stall_o(cpu_stall_o), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
   .flash_data_i(flash_data_i), .flash_valid_i(flash_valid_i));
`default_nettype wire
